// ==== bench/rjt_chk.sv ====
// port assertions for the configuration bank
`timescale 1ns/1ps
module rjt_chk #(
	parameter int OC_TIMEOUT = 16
) (
	input wire logic CLOCK_I, // clock
	input wire logic RESET_N_I, // reset, active low
	input wire logic [10:0] ADDR_I, // address
	input wire logic [7:0] WDATA_I, // write data
	input wire logic WR_I, // write strobe
	input wire logic RD_I, // read strobe
	input wire logic [7:0] RDATA_O, // read data
	input wire logic [21:0] TX_OPEN_CIRCUIT_DETECT_I, // open circuit
	input wire logic [21:0] RX_ATTEN_ON_O, // attenuator on
	input wire logic [21:0] TX_TIP_OUT_OE_N_O, // tip enable, low drives
	input wire logic [21:0] TX_RING_OUT_OE_N_O, // ring enable, low drives
	input wire logic [21:0] TX_POWER_DOWN_O, // power down
	input wire logic [21:0] TX_CURRENT_LIMIT_O, // current limit
	input wire logic [21:0] TX_SINGLE_ENDED_SEL_O // tip only
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_wr(logic [10:0] a);
		WR_I && ADDR_I == a;
	endsequence
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00) else $error("read data outside slot");
	AST_RX_ON: assert property (s_wr(11'h003) |=> RX_ATTEN_ON_O[1] == $past(WDATA_I[3])) else $error("rx on");
	AST_TX_PD: assert property (s_wr(11'h004) |=> TX_POWER_DOWN_O[1] == $past(WDATA_I[5])) else $error("tx pd");
	AST_TX_HIZ: assert property (s_wr(11'h004) ##0 !WDATA_I[6] |=> TX_TIP_OUT_OE_N_O[1] && TX_RING_OUT_OE_N_O[1])
		else $error("driver not high impedance");
	AST_SINGLE: assert property ((TX_SINGLE_ENDED_SEL_O & ~TX_RING_OUT_OE_N_O) == 22'h0) else $error("ring driven");
	AST_LIMIT_ON: assert property ($rose(TX_OPEN_CIRCUIT_DETECT_I[1]) |-> ##2 TX_CURRENT_LIMIT_O[1])
		else $error("no current limit");
	AST_LIMIT_WHY: assert property (TX_CURRENT_LIMIT_O[1] |-> $past(TX_OPEN_CIRCUIT_DETECT_I[1], 2))
		else $error("limit without open circuit");
	AST_CH0_MAP: assert property (s_wr(11'h7c4) |=> TX_POWER_DOWN_O[0] == $past(WDATA_I[5])) else $error("ch0 map");
endmodule : rjt_chk
bind rjt_config_bank rjt_chk #(.OC_TIMEOUT(OC_TIMEOUT)) chk_u (.CLOCK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I,
	.RD_I, .RDATA_O, .TX_OPEN_CIRCUIT_DETECT_I, .RX_ATTEN_ON_O, .TX_TIP_OUT_OE_N_O, .TX_RING_OUT_OE_N_O,
	.TX_POWER_DOWN_O, .TX_CURRENT_LIMIT_O, .TX_SINGLE_ENDED_SEL_O);

// ==== bench/tb_top.sv ====
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb_top;
	import rjt_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [10:0] addr = 0;
	logic [7:0] wd = 0, rdv, v;
	logic [175:0] fill = 0, dep;
	logic [21:0] det = 0, on, cor, su, sd, tip, ring, pd, cl, sing, m120, m75, mnx, mext;
	logic [7:0] tv[4] = '{8'h42, 8'h4a, 8'h62, 8'h02};
	logic te[4] = '{0, 0, 1, 1};
	logic re[4] = '{0, 1, 1, 1};
	int err_count = 0, checks = 0, cyc = 0, ch;
	always #2.5 clk = ~clk;
	rjt_config_bank #(.OC_TIMEOUT(16)) dut_u (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdv), .RX_ATTEN_FILL_I(fill), .TX_OPEN_CIRCUIT_DETECT_I(det),
		.RX_ATTEN_ON_O(on), .RX_ATTEN_FIFO_DEPTH_O(dep), .RX_ATTEN_CORNER_SEL_O(cor), .RX_ATTEN_SPEED_UP_O(su),
		.RX_ATTEN_SLOW_DOWN_O(sd), .TX_TIP_OUT_OE_N_O(tip), .TX_RING_OUT_OE_N_O(ring), .TX_POWER_DOWN_O(pd),
		.TX_CURRENT_LIMIT_O(cl), .TX_SINGLE_ENDED_SEL_O(sing), .TX_MATCH_INT_120_O(m120), .TX_MATCH_INT_75_O(m75),
		.TX_MATCH_INT_120_NOXF_O(mnx), .TX_MATCH_EXT_O(mext));
	task automatic wrap_up;
		$display("err_count %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic ln(input logic l, input logic t);
		chk("limit", 8'(l), 8'(cl[1]));
		chk("tip", 8'(t), 8'(tip[1]));
	endtask : ln
	function automatic logic [10:0] ad(input int c, input logic [5:0] o);
		return {(c == 0) ? 5'h1f : 5'(c - 1), o};
	endfunction : ad
	function automatic logic [7:0] dpth(input int c);
		return c[1] ? 8'h20 : (c[0] ? 8'h40 : 8'h80);
	endfunction : dpth
	task automatic wrt(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		#1;
	endtask : wrt
	task automatic rdc(input logic [10:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk("rdata", e, rdv);
	endtask : rdc
	task automatic fl(input logic [7:0] f);
		@(posedge clk);
		fill[15:8] <= f;
		@(posedge clk);
		#1;
	endtask : fl
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(86));
		repeat (4) @(posedge clk);
		rst_n <= 1;
		rdc(ad(0, 6'h03), 8'h00);
		rdc(ad(0, 6'h04), 8'h00);
		chk("depth", 8'h80, dep[15:8]);
		for (int i = 0; i < 40; i++) begin
			ch = $urandom_range(21, 0);
			v = 8'($urandom);
			v[1] = 1'b1;
			wrt(ad(ch, 6'h03), v);
			wrt(ad(ch, 6'h04), v);
			rdc(ad(ch, 6'h03), v & 8'h1f);
			rdc(ad(ch, 6'h04), v & 8'h7f);
		end
		rdc(11'h005, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wrt(ad(1, 6'h03), 8'h19 | 8'(c << 1));
			chk("depth", dpth(c), dep[15:8]);
			chk("on_corner", 8'h03, {on[1], cor[1]});
			fl(dpth(c) - 8'h02);
			chk("near_full", 8'h02, {su[1], sd[1]});
			fl(dpth(c) - 8'h03);
			chk("middle", 8'h00, {su[1], sd[1]});
			fl(8'h02);
			chk("near_empty", 8'h01, {su[1], sd[1]});
		end
		wrt(ad(1, 6'h03), 8'h10);
		chk("bypass", 8'h00, {on[1], su[1], sd[1], cor[1]});
		for (int c = 0; c < 8; c++) begin
			wrt(ad(1, 6'h04), 8'(c | 2));
			chk("match", {4'h0, (c | 2) == 2, (c | 2) == 3, (c | 2) == 6, (c | 2) == 7},
				{4'h0, m120[1], m75[1], mnx[1], mext[1]});
		end
		foreach (tv[i]) begin
			wrt(ad(1, 6'h04), tv[i]);
			chk("drive", {4'h0, te[i], re[i], tv[i][5], tv[i][3]}, {4'h0, tip[1], ring[1], pd[1], sing[1]});
		end
		wrt(ad(1, 6'h04), 8'h42);
		@(posedge clk);
		det[1] <= 1;
		repeat (40) @(posedge clk);
		#1 ln(1, 0);
		wrt(ad(1, 6'h04), 8'h52);
		repeat (8) @(posedge clk);
		#1 ln(1, 0);
		repeat (12) @(posedge clk);
		#1 ln(0, 1);
		det[1] <= 0;
		repeat (4) @(posedge clk);
		#1 ln(0, 0);
		wrap_up();
	end
endmodule : tb_top

// ==== hw/rjt_config_bank.sv ====
// per-channel receive attenuator and transmit driver configuration bank
`timescale 1ns/1ps

module rjt_config_bank #(
	parameter int OC_TIMEOUT = rjt_pkg::OC_TIMEOUT_CYCLES
) (
	input wire logic CLOCK_I, // 200 MHz clock
	input wire logic RESET_N_I, // async reset, active low
	input wire logic [rjt_pkg::ADDR_W-1:0] ADDR_I, // register address
	input wire logic [rjt_pkg::DATA_W-1:0] WDATA_I, // write data
	input wire logic WR_I, // write strobe
	input wire logic RD_I, // read strobe
	output logic [rjt_pkg::DATA_W-1:0] RDATA_O, // read data, cycle after strobe
	input wire logic [rjt_pkg::NUM_CH*8-1:0] RX_ATTEN_FILL_I, // fifo fill per channel, bits
	input wire logic [rjt_pkg::NUM_CH-1:0] TX_OPEN_CIRCUIT_DETECT_I, // open circuit seen, async
	output logic [rjt_pkg::NUM_CH-1:0] RX_ATTEN_ON_O, // attenuator in receive path
	output logic [rjt_pkg::NUM_CH*8-1:0] RX_ATTEN_FIFO_DEPTH_O, // fifo depth in bits
	output logic [rjt_pkg::NUM_CH-1:0] RX_ATTEN_CORNER_SEL_O, // 1: 0.87 Hz, 0: 6.77 Hz
	output logic [rjt_pkg::NUM_CH-1:0] RX_ATTEN_SPEED_UP_O, // fifo near full, read faster
	output logic [rjt_pkg::NUM_CH-1:0] RX_ATTEN_SLOW_DOWN_O, // fifo near empty, read slower
	output logic [rjt_pkg::NUM_CH-1:0] TX_TIP_OUT_OE_N_O, // tip driver enable, low drives
	output logic [rjt_pkg::NUM_CH-1:0] TX_RING_OUT_OE_N_O, // ring driver enable, low drives
	output logic [rjt_pkg::NUM_CH-1:0] TX_POWER_DOWN_O, // transmitter powered down
	output logic [rjt_pkg::NUM_CH-1:0] TX_CURRENT_LIMIT_O, // driver current limited
	output logic [rjt_pkg::NUM_CH-1:0] TX_SINGLE_ENDED_SEL_O, // tip-only drive
	output logic [rjt_pkg::NUM_CH-1:0] TX_MATCH_INT_120_O, // internal 120 ohm, transformer
	output logic [rjt_pkg::NUM_CH-1:0] TX_MATCH_INT_75_O, // internal 75 ohm, transformer
	output logic [rjt_pkg::NUM_CH-1:0] TX_MATCH_INT_120_NOXF_O, // internal 120 ohm, no transformer
	output logic [rjt_pkg::NUM_CH-1:0] TX_MATCH_EXT_O // external matching
);
	import rjt_pkg::*;

	localparam int CNT_W = $clog2(OC_TIMEOUT + 1);

	initial begin
		if (OC_TIMEOUT < 1 || CNT_W > 31) begin
			$error("OC_TIMEOUT out of range");
		end
	end

	// ****************************************
	// address decode
	// ****************************************
	// slot 1fH is channel 0, slots 0..20 are channels 1..21
	function automatic logic [5:0] chan_of(input logic [ADDR_W-1:0] a);
		logic [4:0] slot;
		slot = a[ADDR_W-1:6];
		if (slot == CH0_SLOT) begin
			chan_of = 6'h00;
		end else if (slot <= LAST_SLOT) begin
			chan_of = 6'(slot) + 6'h01;
		end else begin
			chan_of = 6'h3f;
		end
	endfunction : chan_of

	wire [5:0] bus_chan = chan_of(ADDR_I);
	wire chan_ok = bus_chan != 6'h3f;
	wire hit_rx = chan_ok && ADDR_I[5:0] == RX_ATTEN_OFS;
	wire hit_tx = chan_ok && ADDR_I[5:0] == TX_DRIVER_OFS;

	logic [7:0] rx_attenuator [NUM_CH];
	logic [7:0] tx_driver [NUM_CH];
	logic [NUM_CH-1:0] oc_meta;
	logic [NUM_CH-1:0] oc_sync;

	// ****************************************
	// register read
	// ****************************************
	wire [7:0] next_rdata = hit_rx ? rx_attenuator[bus_chan[4:0]] :
		hit_tx ? tx_driver[bus_chan[4:0]] : 8'h00;

	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= RD_I ? next_rdata : 8'h00;
		end
	end

	// only the first stage feeds the second
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			oc_meta <= '0;
			oc_sync <= '0;
		end else begin
			oc_meta <= TX_OPEN_CIRCUIT_DETECT_I;
			oc_sync <= oc_meta;
		end
	end

	// ****************************************
	// per-channel logic
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			wire wr_rx = WR_I && hit_rx && bus_chan == 6'(ch);
			wire wr_tx = WR_I && hit_tx && bus_chan == 6'(ch);
			logic [CNT_W-1:0] oc_count;
			wire [7:0] rx = rx_attenuator[ch];
			wire [7:0] tx = tx_driver[ch];
			wire [1:0] depth_code = rx[RX_DEPTH_LSB +: 2];
			wire [7:0] depth = depth_code[1] ? DEPTH_32 : (depth_code[0] ? DEPTH_64 : DEPTH_128);
			wire [8:0] fill = {1'b0, RX_ATTEN_FILL_I[ch*8 +: 8]};
			wire limit_on = rx[RX_ON_BIT] && rx[RX_LIMIT_BIT];
			wire [2:0] match = tx[TX_MATCH_LSB +: 3];
			wire oc_expired = oc_count == CNT_W'(OC_TIMEOUT);
			wire oc_hiz = tx[TX_OC_TRISTATE_BIT] && oc_sync[ch] && oc_expired;
			// powered down or timed out also releases the line
			wire drive = tx[TX_OUT_ENABLE_BIT] && !tx[TX_POWER_DOWN_BIT] && !oc_hiz;

			// reserved bits are not stored and read back as zero
			always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					rx_attenuator[ch] <= RX_ATTEN_RESET;
					tx_driver[ch] <= TX_DRIVER_RESET;
				end else begin
					if (wr_rx) begin
						rx_attenuator[ch] <= WDATA_I & RX_ATTEN_USED;
					end
					if (wr_tx) begin
						tx_driver[ch] <= WDATA_I & TX_DRIVER_USED;
					end
				end
			end

			// counts while open circuit persists, saturates at the timeout
			always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					oc_count <= '0;
				end else if (!oc_sync[ch] || wr_tx) begin
					oc_count <= '0;
				end else if (!oc_expired) begin
					oc_count <= oc_count + CNT_W'(1);
				end
			end

			assign RX_ATTEN_ON_O[ch] = rx[RX_ON_BIT];
			assign RX_ATTEN_FIFO_DEPTH_O[ch*8 +: 8] = depth;
			assign RX_ATTEN_CORNER_SEL_O[ch] = rx[RX_CORNER_BIT];
			assign RX_ATTEN_SPEED_UP_O[ch] = limit_on && fill + {1'b0, FIFO_MARGIN} >= {1'b0, depth};
			assign RX_ATTEN_SLOW_DOWN_O[ch] = limit_on && fill <= {1'b0, FIFO_MARGIN};
			assign TX_TIP_OUT_OE_N_O[ch] = !drive;
			assign TX_RING_OUT_OE_N_O[ch] = !(drive && !tx[TX_SINGLE_BIT]);
			assign TX_POWER_DOWN_O[ch] = tx[TX_POWER_DOWN_BIT];
			assign TX_CURRENT_LIMIT_O[ch] = oc_sync[ch] && !oc_hiz;
			assign TX_SINGLE_ENDED_SEL_O[ch] = tx[TX_SINGLE_BIT];
			assign TX_MATCH_INT_120_O[ch] = match == MATCH_INT_120;
			assign TX_MATCH_INT_75_O[ch] = match == MATCH_INT_75;
			assign TX_MATCH_INT_120_NOXF_O[ch] = match == MATCH_INT_120_NOXF;
			assign TX_MATCH_EXT_O[ch] = match == MATCH_EXTERNAL;
		end
	endgenerate

endmodule : rjt_config_bank

// ==== inc/rjt_pkg.sv ====
// constants for the per-channel receive attenuator and transmit driver configuration bank

package rjt_pkg;

	// ****************************************
	// bus and channel map
	// ****************************************
	localparam int NUM_CH = 22;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam logic [5:0] RX_ATTEN_OFS = 6'h03;
	localparam logic [5:0] TX_DRIVER_OFS = 6'h04;
	localparam logic [4:0] CH0_SLOT = 5'h1f;
	localparam logic [4:0] LAST_SLOT = 5'h14;

	// ****************************************
	// register fields and reset values
	// ****************************************
	localparam logic [7:0] RX_ATTEN_RESET = 8'h00;
	localparam logic [7:0] TX_DRIVER_RESET = 8'h00;
	localparam int RX_CORNER_BIT = 0;
	localparam int RX_DEPTH_LSB = 1;
	localparam int RX_ON_BIT = 3;
	localparam int RX_LIMIT_BIT = 4;
	localparam logic [7:0] RX_ATTEN_USED = 8'h1f;
	localparam int TX_MATCH_LSB = 0;
	localparam int TX_SINGLE_BIT = 3;
	localparam int TX_OC_TRISTATE_BIT = 4;
	localparam int TX_POWER_DOWN_BIT = 5;
	localparam int TX_OUT_ENABLE_BIT = 6;
	localparam logic [7:0] TX_DRIVER_USED = 8'h7f;

	// ****************************************
	// attenuator fifo and matching codes
	// ****************************************
	localparam logic [7:0] DEPTH_128 = 8'h80;
	localparam logic [7:0] DEPTH_64 = 8'h40;
	localparam logic [7:0] DEPTH_32 = 8'h20;
	localparam logic [7:0] FIFO_MARGIN = 8'h02;
	localparam logic [2:0] MATCH_INT_120 = 3'h2;
	localparam logic [2:0] MATCH_INT_75 = 3'h3;
	localparam logic [2:0] MATCH_INT_120_NOXF = 3'h6;
	localparam logic [2:0] MATCH_EXTERNAL = 3'h7;

	// ****************************************
	// open-circuit timeout
	// ****************************************
	localparam int CLOCK_MHZ = 200;
	localparam int OC_TIMEOUT_US = 1000;
	localparam int OC_TIMEOUT_CYCLES = OC_TIMEOUT_US * CLOCK_MHZ;

endpackage : rjt_pkg
